//--- logic/fepc_pkg.sv
// constants and types shared by the flash erase and protection controller
// What this block does
// R1 - control register one selects program, verify, erase modes
// R2 - erase works from any contents, no prewrite
// R3 - software selects one block per erase
// R4 - erase pulse lasts while erase enable set
// R5 - software runs overflow guard during erase
// R6 - dummy write FF at aligned address enables verify
// R7 - software repeats erase and verify, 100 maximum
// R8 - block all interrupts during program or erase
// R9 - reset, subsleep, standby abort and clear registers
// R10 - write enable clear prevents program and erase
// R11 - block select masks erase; zero protects all
// R12 - flash read during operation sets error flag
// R13 - non-reset exception during operation sets error
// R14 - sleep during operation sets error flag
// R15 - error aborts operation, registers keep contents
// R16 - in error, only verify modes enterable
// R17 - only power-on reset clears error protection
// R18 - error flag readable, software writes ignored
package fepc_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets on the register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] FEPC_ADDR_CTRL_ONE  = 4'h0;
    localparam logic [3:0] FEPC_ADDR_CTRL_TWO  = 4'h1;
    localparam logic [3:0] FEPC_ADDR_BLOCK_SEL = 4'h2;
    localparam logic [3:0] FEPC_ADDR_IRQ_STAT  = 4'h3;
    localparam logic [3:0] FEPC_ADDR_IRQ_MASK  = 4'h4;
    localparam logic [3:0] FEPC_ADDR_VERIFY    = 4'h5;

    // ----------------------------------------------------------------
    // control register one fields, then the error flag bit of control register two
    // ----------------------------------------------------------------
    localparam int FEPC_BIT_PROG_EN  = 0;
    localparam int FEPC_BIT_ERASE_EN = 1;
    localparam int FEPC_BIT_PROG_VFY  = 2;
    localparam int FEPC_BIT_ERASE_VFY = 3;
    localparam int FEPC_BIT_WR_EN     = 6;
    localparam logic [7:0] FEPC_CTRL_ONE_MASK = 8'h4F;
    localparam int FEPC_BIT_ERR_FLAG  = 7;

    // interrupt status bits
    localparam int FEPC_IRQ_ERROR    = 0;
    localparam int FEPC_IRQ_ERASE_END = 1;

    localparam logic [7:0] FEPC_RESET_BYTE  = 8'h00;
    localparam logic [7:0] FEPC_DUMMY_DATA  = 8'hFF;
    localparam logic [1:0] FEPC_ALIGN_LOW   = 2'h0;

    typedef enum logic [1:0] {
        FEPC_IDLE   = 2'b00,
        FEPC_ACTIVE = 2'b01,
        FEPC_ERROR  = 2'b11
    } fepc_state_t;

    // strap synchroniser depth
    localparam int FEPC_SYNC_DEPTH = 2;

endpackage

//--- logic/fepc_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module fepc_sync
    import fepc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- logic/fepc_irq.sv
// sticky status, mask and level interrupt for the controller
`timescale 1ns/10ps
module fepc_irq
    import fepc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [1:0] event_set,
    input  wire logic [1:0] clear_ones,
    input  wire logic       mask_we,
    input  wire logic [1:0] mask_wdata,
    output logic      [1:0] status_q,
    output logic      [1:0] mask_q,
    output logic            irq_q
);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_q <= '0;
        end else begin
            // set beats a simultaneous clear
            status_q <= (status_q & ~clear_ones) | event_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mask_q <= '0;
        end else if (mask_we) begin
            mask_q <= mask_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((status_q & ~clear_ones) | event_set) & mask_q);
        end
    end
endmodule

//--- logic/fepc_top.sv
// flash erase sequencer with hardware, software and error protection
`timescale 1ns/10ps
module fepc_top
    import fepc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       por_n,
    input  wire logic       subsleep_req,
    input  wire logic       standby_req,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    output logic      [7:0] reg_rdata,
    input  wire logic       cpu_flash_read,
    input  wire logic       cpu_exception,
    input  wire logic       cpu_sleep,
    input  wire logic       boot_running,
    input  wire logic       flash_wr,
    input  wire logic [1:0] flash_wr_addr_low,
    input  wire logic [7:0] flash_wr_data,
    output logic      [7:0] erase_pulse_q,
    output logic            prog_pulse_q,
    output logic            verify_prog_q,
    output logic            verify_erase_q,
    output logic            verify_armed_q,
    output logic            irq_block_q,
    output logic            flash_error_q,
    output logic            irq
);
    // ----------------------------------------------------------------
    // low-power and power-on inputs: two flops before use
    // ----------------------------------------------------------------
    logic [1:0] lowpwr_s;
    logic       por_s;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [1:0] event_set;
    logic [1:0] clear_ones;
    logic       irq_q;

    fepc_sync #(.WIDTH(2)) u_sync_pwr (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({standby_req, subsleep_req}),
        .sync_out (lowpwr_s)
    );

    fepc_sync #(.WIDTH(1)) u_sync_por (
        .core_clk (core_clk),
        .rstn     (1'b1),
        .async_in (por_n),
        .sync_out (por_s)
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_one_q;
    logic [7:0]  block_sel_q;
    fepc_state_t state_q;
    logic        hw_abort;
    logic        busy;
    logic        err_event;

    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off);
        return reg_we && (a == off);
    endfunction

    function automatic logic verify_on(input logic [7:0] c);
        return c[FEPC_BIT_PROG_VFY] || c[FEPC_BIT_ERASE_VFY];
    endfunction

    assign hw_abort = |lowpwr_s; // R9
    assign busy     = ctrl_one_q[FEPC_BIT_WR_EN] && (state_q != FEPC_ERROR) // R10
                    && (ctrl_one_q[FEPC_BIT_PROG_EN] || ctrl_one_q[FEPC_BIT_ERASE_EN]);
    assign err_event = busy && (cpu_flash_read || cpu_exception || cpu_sleep); // R12 R13 R14

    // registers cleared by reset or low-power entry, kept through error
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_one_q <= FEPC_RESET_BYTE; // R9
        end else if (hw_abort) begin
            ctrl_one_q <= FEPC_RESET_BYTE; // R9
        end else if (wr_hit(reg_addr, FEPC_ADDR_CTRL_ONE)) begin
            ctrl_one_q <= reg_wdata & FEPC_CTRL_ONE_MASK; // R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            block_sel_q <= FEPC_RESET_BYTE; // R9
        end else if (hw_abort) begin
            block_sel_q <= FEPC_RESET_BYTE; // R9
        end else if (wr_hit(reg_addr, FEPC_ADDR_BLOCK_SEL)) begin
            block_sel_q <= reg_wdata; // R3
        end
    end

    // ----------------------------------------------------------------
    // error protection state
    // ----------------------------------------------------------------
    // error protection survives ordinary reset; only power-on clears it
    always_ff @(posedge core_clk) begin
        if (!por_s) begin
            state_q <= FEPC_IDLE; // R17
        end else begin
            case (state_q)
                FEPC_ERROR: begin
                    state_q <= FEPC_ERROR; // R17
                end
                default: begin
                    if (err_event) begin
                        state_q <= FEPC_ERROR; // R12 R13 R14
                    end else if (busy && rstn && !hw_abort) begin
                        state_q <= FEPC_ACTIVE;
                    end else begin
                        state_q <= FEPC_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // flash array drive
    // ----------------------------------------------------------------
    // erase pulse held only while enable bit stays set; no prewrite needed
    always_ff @(posedge core_clk) begin
        if (!rstn || hw_abort || err_event) begin
            erase_pulse_q <= FEPC_RESET_BYTE; // R15
        end else if (busy && ctrl_one_q[FEPC_BIT_ERASE_EN]) begin
            erase_pulse_q <= block_sel_q; // R4 R11 R2
        end else begin
            erase_pulse_q <= FEPC_RESET_BYTE; // R4
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || hw_abort || err_event) begin
            prog_pulse_q <= 1'b0; // R15
        end else begin
            prog_pulse_q <= busy && ctrl_one_q[FEPC_BIT_PROG_EN]; // R1 R16
        end
    end

    // verify still allowed in error protection
    always_ff @(posedge core_clk) begin
        if (!rstn || hw_abort) begin
            verify_prog_q  <= 1'b0;
            verify_erase_q <= 1'b0;
        end else begin
            verify_prog_q  <= ctrl_one_q[FEPC_BIT_PROG_VFY]; // R16
            verify_erase_q <= ctrl_one_q[FEPC_BIT_ERASE_VFY]; // R16
        end
    end

    // dummy write arms verify read
    always_ff @(posedge core_clk) begin
        if (!rstn || hw_abort) begin
            verify_armed_q <= 1'b0;
        end else if (!verify_on(ctrl_one_q)) begin
            verify_armed_q <= 1'b0;
        end else if (flash_wr && flash_wr_data == FEPC_DUMMY_DATA
                     && flash_wr_addr_low == FEPC_ALIGN_LOW) begin
            verify_armed_q <= 1'b1; // R6
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_block_q <= 1'b0;
        end else begin
            irq_block_q <= (busy && !err_event && !hw_abort) || boot_running; // R8
        end
    end

    always_ff @(posedge core_clk) begin
        if (!por_s) begin
            flash_error_q <= 1'b0; // R17
        end else begin
            flash_error_q <= (state_q == FEPC_ERROR) || err_event; // R12 R18
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic erase_was_q;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            erase_was_q <= 1'b0;
        end else begin
            erase_was_q <= |erase_pulse_q;
        end
    end

    // an erase aborted by error or low-power entry raises erase end too, so software sees the stop
    assign event_set  = {erase_was_q && !(|erase_pulse_q), err_event};
    assign clear_ones = wr_hit(reg_addr, FEPC_ADDR_IRQ_STAT) ? reg_wdata[1:0] : 2'h0;

    fepc_irq u_irq (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .event_set  (event_set),
        .clear_ones (clear_ones),
        .mask_we    (wr_hit(reg_addr, FEPC_ADDR_IRQ_MASK)),
        .mask_wdata (reg_wdata[1:0]),
        .status_q   (status_q),
        .mask_q     (mask_q),
        .irq_q      (irq_q)
    );

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_q;
        end
    end

    // ----------------------------------------------------------------
    // read port: data one cycle after strobe, else zero
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= FEPC_RESET_BYTE;
        end else if (reg_re) begin
            case (reg_addr)
                FEPC_ADDR_CTRL_ONE:  reg_rdata <= ctrl_one_q;
                FEPC_ADDR_CTRL_TWO:  reg_rdata <= {flash_error_q, 7'h00}; // R18
                FEPC_ADDR_BLOCK_SEL: reg_rdata <= block_sel_q;
                FEPC_ADDR_IRQ_STAT:  reg_rdata <= {6'h00, status_q};
                FEPC_ADDR_IRQ_MASK:  reg_rdata <= {6'h00, mask_q};
                FEPC_ADDR_VERIFY:    reg_rdata <= {7'h00, verify_armed_q};
                default:             reg_rdata <= FEPC_RESET_BYTE;
            endcase
        end else begin
            reg_rdata <= FEPC_RESET_BYTE;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    wren_gates_erase_a: assert property (@(posedge core_clk) disable iff (!rstn) // R10
        !ctrl_one_q[FEPC_BIT_WR_EN] |=> erase_pulse_q == 8'h00) else $error("erase without write enable");
    erase_follows_en_a: assert property (@(posedge core_clk) disable iff (!rstn || hw_abort) // R4
        busy && ctrl_one_q[FEPC_BIT_ERASE_EN] && !err_event |=> erase_pulse_q == $past(block_sel_q))
        else $error("erase pulse not following enable");
    mask_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // R11
        block_sel_q == 8'h00 |=> erase_pulse_q == 8'h00) else $error("erase with empty mask");
    irq_blocked_a: assert property (@(posedge core_clk) disable iff (!rstn || hw_abort) // R8
        busy && !err_event |=> irq_block_q) else $error("interrupts not blocked");
    err_sets_flag_a: assert property (@(posedge core_clk) disable iff (!por_s) // R12
        err_event |=> flash_error_q ##1 flash_error_q) else $error("error flag not set");
    err_aborts_a: assert property (@(posedge core_clk) disable iff (!rstn) // R15
        err_event |=> erase_pulse_q == 8'h00 && !prog_pulse_q) else $error("abort missing");
    err_sticky_a: assert property (@(posedge core_clk) disable iff (!por_s) // R17
        flash_error_q |=> flash_error_q) else $error("error flag dropped");
    err_no_reentry_a: assert property (@(posedge core_clk) disable iff (!rstn) // R16
        state_q == FEPC_ERROR |=> !prog_pulse_q && erase_pulse_q == 8'h00) else $error("reentered in error");
    hw_clears_a: assert property (@(posedge core_clk) disable iff (!rstn) // R9
        hw_abort |=> ctrl_one_q == 8'h00 && block_sel_q == 8'h00) else $error("low power did not clear");

    // drive, readback and retention
    wren_blocks_prog_a: assert property (@(posedge core_clk) disable iff (!rstn) // R10
        !ctrl_one_q[FEPC_BIT_WR_EN] |=> !prog_pulse_q)
        else $error("program without write enable");
    verify_in_error_a: assert property (@(posedge core_clk) disable iff (!rstn || hw_abort) // R16
        state_q == FEPC_ERROR && ctrl_one_q[FEPC_BIT_ERASE_VFY] |=> verify_erase_q)
        else $error("verify refused in error");
    boot_blocks_irq_a: assert property (@(posedge core_clk) disable iff (!rstn) // R8
        boot_running |=> irq_block_q)
        else $error("interrupts open during boot");
    hw_stops_drive_a: assert property (@(posedge core_clk) disable iff (!rstn) // R9
        hw_abort |=> erase_pulse_q == 8'h00 && !prog_pulse_q && !verify_armed_q)
        else $error("low power left array driven");
    flag_readback_a: assert property (@(posedge core_clk) disable iff (!rstn) // R18
        reg_re && reg_addr == FEPC_ADDR_CTRL_TWO |=> reg_rdata == {$past(flash_error_q), 7'h00})
        else $error("error flag read wrong");
    verify_arm_a: assert property (@(posedge core_clk) disable iff (!rstn || hw_abort) // R6
        verify_on(ctrl_one_q) && flash_wr && flash_wr_data == FEPC_DUMMY_DATA
        && flash_wr_addr_low == FEPC_ALIGN_LOW |=> verify_armed_q)
        else $error("dummy write did not arm verify");
    erase_end_sets_a: assert property (@(posedge core_clk) disable iff (!rstn) // R4
        erase_was_q && !(|erase_pulse_q) |=> status_q[FEPC_IRQ_ERASE_END])
        else $error("erase end not flagged");
    err_needs_busy_a: assert property (@(posedge core_clk) disable iff (!por_s) // R13
        !busy && state_q != FEPC_ERROR |=> !flash_error_q)
        else $error("error flag without operation");
    err_keeps_regs_a: assert property (@(posedge core_clk) disable iff (!rstn) // R15
        err_event && !hw_abort && !reg_we
        |=> ctrl_one_q == $past(ctrl_one_q) && block_sel_q == $past(block_sel_q))
        else $error("error changed registers");

    erase_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) |erase_pulse_q);
    error_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) err_event);
    verify_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) verify_armed_q);
    prog_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) prog_pulse_q);
    lowpwr_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) hw_abort);
endmodule

//--- verification/fepc_cpu_model.sv
// processor-side model driving the register port and the flash write path
`timescale 1ns/10ps
module fepc_cpu_model
    import fepc_pkg::*;
#(
    parameter int GUARD_CYC = 2000
) (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_we,
    output logic            reg_re,
    output logic            flash_wr,
    output logic      [1:0] flash_wr_addr_low,
    output logic      [7:0] flash_wr_data,
    output logic      [2:0] cpu_evt
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
        flash_wr = 1'b0;
        flash_wr_addr_low = 2'h3;
        flash_wr_data = 8'h00;
        cpu_evt = 3'h0;
    end
    // released data lines show the inverse so stale values never pass
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge core_clk);
        reg_we <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic dummy(input logic [1:0] lo, input logic [7:0] d);
        @(posedge core_clk);
        flash_wr <= 1'b1;
        flash_wr_addr_low <= lo;
        flash_wr_data <= d;
        @(posedge core_clk);
        flash_wr <= 1'b0;
        flash_wr_data <= ~d;
    endtask
    task automatic strobe_fault(input int k);
        @(posedge core_clk);
        cpu_evt <= 3'h1 << k;
        @(posedge core_clk);
        cpu_evt <= 3'h0;
    endtask
    // one block per pass, erase time capped by the guard count
    task automatic erase_verify(input logic [7:0] blk, input int cyc, output int tries);
        logic [7:0] seen;
        tries = 0;
        for (int n = 0; n < 100; n++) begin
            tries++;
            wr(FEPC_ADDR_BLOCK_SEL, blk);
            wr(FEPC_ADDR_CTRL_ONE, 8'h42);
            repeat ((cyc < GUARD_CYC) ? cyc : GUARD_CYC) @(posedge core_clk);
            wr(FEPC_ADDR_CTRL_ONE, 8'h48);
            dummy(FEPC_ALIGN_LOW, FEPC_DUMMY_DATA);
            // erased data is not modelled: a verify that arms counts as erased
            rd(FEPC_ADDR_VERIFY, seen);
            if (seen[0]) begin
                break;
            end
        end
        wr(FEPC_ADDR_CTRL_ONE, 8'h40);
    endtask
endmodule

//--- verification/fepc_test.sv
// self-checking bench for the flash erase and protection controller
`timescale 1ns/10ps
module fepc_test
    import fepc_pkg::*;
();
    logic       core_clk, rstn, por_n, subsleep_req, standby_req, boot_running;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, flash_wr_data, erase_pulse_q, v;
    logic       reg_we, reg_re, flash_wr, prog_pulse_q, verify_prog_q, verify_erase_q;
    logic       verify_armed_q, irq_block_q, flash_error_q, irq;
    logic [1:0] flash_wr_addr_low;
    logic [2:0] cpu_evt;
    int         err_total, n_compared, tries;
    fepc_cpu_model cpu (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .flash_wr(flash_wr),
        .flash_wr_addr_low(flash_wr_addr_low), .flash_wr_data(flash_wr_data), .cpu_evt(cpu_evt));
    fepc_top dut (.core_clk(core_clk), .rstn(rstn), .por_n(por_n), .subsleep_req(subsleep_req),
        .standby_req(standby_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .cpu_flash_read(cpu_evt[0]),
        .cpu_exception(cpu_evt[1]), .cpu_sleep(cpu_evt[2]), .boot_running(boot_running),
        .flash_wr(flash_wr), .flash_wr_addr_low(flash_wr_addr_low), .flash_wr_data(flash_wr_data),
        .erase_pulse_q(erase_pulse_q), .prog_pulse_q(prog_pulse_q), .verify_prog_q(verify_prog_q),
        .verify_erase_q(verify_erase_q), .verify_armed_q(verify_armed_q),
        .irq_block_q(irq_block_q), .flash_error_q(flash_error_q), .irq(irq));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
        cpu.rd(ad, v);
        chk(v, exp);
    endtask
    task automatic wc(input logic [7:0] d);
        cpu.wr(FEPC_ADDR_CTRL_ONE, d);
        settle();
    endtask
    // por held past the synchroniser depth, core reset alongside
    task automatic rst(input logic with_por);
        @(posedge core_clk);
        rstn <= 1'b0;
        por_n <= ~with_por;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        settle();
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_modes();
        rchk(FEPC_ADDR_CTRL_ONE, 8'h00);
        rchk(FEPC_ADDR_CTRL_TWO, 8'h00);
        cpu.wr(FEPC_ADDR_BLOCK_SEL, 8'h01);
        wc(8'h02);
        chk(erase_pulse_q, 8'h00);
        wc(8'h01);
        chk({7'h00, prog_pulse_q}, 8'h00);
        wc(8'h41);
        chk({7'h00, prog_pulse_q}, 8'h01);
        wc(8'h44);
        chk({6'h00, verify_prog_q, prog_pulse_q}, 8'h02);
        wc(8'h48);
        chk({7'h00, verify_erase_q}, 8'h01);
        cpu.wr(FEPC_ADDR_BLOCK_SEL, 8'h00);
        wc(8'h42);
        chk(erase_pulse_q, 8'h00);
        wc(8'h40);
        $display("test modes done");
    endtask
    task automatic t_erase();
        cpu.wr(FEPC_ADDR_IRQ_STAT, 8'h03);
        cpu.wr(FEPC_ADDR_BLOCK_SEL, 8'h80);
        wc(8'h42);
        chk(erase_pulse_q, 8'h80);
        chk({7'h00, irq_block_q}, 8'h01);
        repeat (50) @(posedge core_clk);
        chk(erase_pulse_q, 8'h80);
        wc(8'h40);
        chk(erase_pulse_q, 8'h00);
        chk({7'h00, irq_block_q}, 8'h00);
        rchk(FEPC_ADDR_IRQ_STAT, 8'h02);
        cpu.wr(FEPC_ADDR_IRQ_MASK, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h00);
        cpu.wr(FEPC_ADDR_IRQ_MASK, 8'h03);
        settle();
        chk({7'h00, irq}, 8'h01);
        rchk(FEPC_ADDR_IRQ_MASK, 8'h03);
        cpu.wr(FEPC_ADDR_IRQ_STAT, 8'h02);
        settle();
        chk({7'h00, irq}, 8'h00);
        rchk(4'hF, 8'h00);
        @(posedge core_clk);
        boot_running <= 1'b1;
        settle();
        chk({7'h00, irq_block_q}, 8'h01);
        @(posedge core_clk);
        boot_running <= 1'b0;
        $display("test erase done");
    endtask
    task automatic t_verify();
        wc(8'h48);
        cpu.dummy(2'h1, FEPC_DUMMY_DATA);
        cpu.dummy(FEPC_ALIGN_LOW, 8'h7F);
        settle();
        chk({7'h00, verify_armed_q}, 8'h00);
        cpu.dummy(FEPC_ALIGN_LOW, FEPC_DUMMY_DATA);
        settle();
        chk({7'h00, verify_armed_q}, 8'h01);
        for (int b = 0; b < 2; b++) begin
            cpu.erase_verify(8'h01 << b, 20, tries);
            chk(8'(tries), 8'h01);
        end
        $display("test verify done");
    endtask
    // error protection per cause, released only by power-on reset
    task automatic t_error(input int k);
        cpu.strobe_fault(k);
        settle();
        chk({7'h00, flash_error_q}, 8'h00);
        cpu.wr(FEPC_ADDR_BLOCK_SEL, 8'h10);
        wc(8'h42);
        cpu.strobe_fault(k);
        settle();
        chk({7'h00, flash_error_q}, 8'h01);
        chk(erase_pulse_q, 8'h00);
        rchk(FEPC_ADDR_CTRL_ONE, 8'h42);
        rchk(FEPC_ADDR_BLOCK_SEL, 8'h10);
        cpu.wr(FEPC_ADDR_CTRL_TWO, 8'h00);
        rchk(FEPC_ADDR_CTRL_TWO, 8'h80);
        wc(8'h40);
        wc(8'h42);
        chk(erase_pulse_q, 8'h00);
        wc(8'h48);
        chk({7'h00, verify_erase_q}, 8'h01);
        rst(1'b0);
        chk({7'h00, flash_error_q}, 8'h01);
        rst(1'b1);
        chk({7'h00, flash_error_q}, 8'h00);
        $display("test error %0d done", k);
    endtask
    task automatic t_hw(input int k);
        cpu.wr(FEPC_ADDR_BLOCK_SEL, 8'h08);
        wc(8'h42);
        chk(erase_pulse_q, 8'h08);
        if (k == 0)
            rst(1'b0);
        @(posedge core_clk);
        subsleep_req <= (k == 1);
        standby_req <= (k == 2);
        settle();
        chk(erase_pulse_q, 8'h00);
        rchk(FEPC_ADDR_CTRL_ONE, 8'h00);
        rchk(FEPC_ADDR_BLOCK_SEL, 8'h00);
        @(posedge core_clk);
        subsleep_req <= 1'b0;
        standby_req <= 1'b0;
        settle();
        $display("test hardware stop %0d done", k);
    endtask
    // ----------------------------------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
    initial begin
        {rstn, por_n, subsleep_req, standby_req, boot_running} = 5'h00;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        settle();
        chk({7'h00, flash_error_q}, 8'h00);
        t_modes();
        t_erase();
        t_verify();
        for (int k = 0; k < 3; k++)
            t_error(k);
        for (int k = 0; k < 3; k++)
            t_hw(k);
        end_of_test();
    end
endmodule
